// File: sbs_burst_sram.sv
/*
  Synchronous pipelined burst memory: write buffer FIFO and the device top.
  Assumes all inputs but the output enable and the sleep request are set up
  around the rising edge of core_clk_in; the shared data bus is resolved
  outside from the per-lane output enables.
*/
`timescale 1ns/1ps
`default_nettype none

module sbs_wr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [PTR_W:0] count_r;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  wire [PTR_W:0] count_nxt = count_r + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};

  // ----------------------------------------------------------------------
  // Pointers and fill level
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      store[wr_ptr_r] <= in_data_in;
    end
  end

  assign in_ready_out = (count_r != (PTR_W+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign out_data_out = store[rd_ptr_r];

endmodule

module sbs_burst_sram
  import sbs_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic proc_addr_strobe_n_in,
  input wire logic ctrl_addr_strobe_n_in,
  input wire logic burst_step_n_in,
  input wire logic chip_sel_primary_n_in,
  input wire logic chip_sel_high_in,
  input wire logic chip_sel_secondary_n_in,
  input wire logic [LANES-1:0] lane_write_n_in,
  input wire logic global_write_n_in,
  input wire logic byte_write_enable_n_in,
  input wire logic output_enable_n_in,
  input wire logic sleep_request_in,
  input wire logic burst_order_select_in,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic [LANES-1:0] data_oe_n_out,
  output logic write_ready_out,
  output logic awake_out
);

  // ----------------------------------------------------------------------
  // Sleep request synchroniser
  // ----------------------------------------------------------------------
  logic [SYNC_STAGES-1:0] sleep_sync_r;
  logic sleep_lvl_r;

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sleep_sync_r <= '0;
      sleep_lvl_r <= 1'b0;
    end else begin
      sleep_sync_r <= {sleep_sync_r[SYNC_STAGES-2:0], sleep_request_in};
      if (sleep_sync_r[1] == sleep_sync_r[2]) begin
        sleep_lvl_r <= sleep_sync_r[2];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------------
  sbs_state_t state_r;
  sbs_state_t state_nxt;
  logic [WAKE_W-1:0] wake_cnt_r;
  logic [WAKE_W-1:0] wake_cnt_nxt;
  wire running = (state_r == SBS_RUN) && !sleep_lvl_r;

  always_comb begin
    state_nxt = state_r;
    wake_cnt_nxt = wake_cnt_r;
    case (state_r)
      SBS_RUN: begin
        if (sleep_lvl_r) begin
          state_nxt = SBS_SLEEP;
        end
      end
      SBS_SLEEP: begin
        if (!sleep_lvl_r) begin
          state_nxt = SBS_WAKE;
          wake_cnt_nxt = WAKE_W'(WAKE_CYCLES - 1);
        end
      end
      SBS_WAKE: begin
        if (sleep_lvl_r) begin
          state_nxt = SBS_SLEEP;
        end else if (wake_cnt_r == WAKE_RST) begin
          state_nxt = SBS_RUN;
        end else begin
          wake_cnt_nxt = wake_cnt_r - 1'b1;
        end
      end
      default: begin
        state_nxt = SBS_SLEEP;
        wake_cnt_nxt = WAKE_RST;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= SBS_RUN;
      wake_cnt_r <= WAKE_RST;
    end else begin
      state_r <= state_nxt;
      wake_cnt_r <= wake_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Cycle decode
  // ----------------------------------------------------------------------
  function automatic logic [BURST_W-1:0] burst_lo(input logic interleave,
                                                  input logic [BURST_W-1:0] start,
                                                  input logic [BURST_W-1:0] count);
    burst_lo = interleave ? (start ^ count) : BURST_W'(start + count);
  endfunction

  logic burst_active_r;
  logic [ADDR_W-1:BURST_W] addr_hi_r;
  logic [BURST_W-1:0] start_lo_r;
  logic [BURST_W-1:0] cnt_r;

  wire sel_ok = !chip_sel_primary_n_in && chip_sel_high_in
                && !chip_sel_secondary_n_in;
  wire proc_strobe = !proc_addr_strobe_n_in && !chip_sel_primary_n_in;
  wire ctrl_strobe = !ctrl_addr_strobe_n_in && !proc_strobe;
  wire any_strobe = proc_strobe || ctrl_strobe;
  wire start_cycle = running && any_strobe && sel_ok;
  wire deselect = running && any_strobe && !sel_ok;
  wire cont_cycle = running && !any_strobe && burst_active_r;
  wire step = cont_cycle && !burst_step_n_in;
  wire [BURST_W-1:0] cnt_nxt = BURST_W'(cnt_r + 1'b1);

  wire [LANES-1:0] lanes_req = !global_write_n_in ? LANES_ALL
                             : (!byte_write_enable_n_in ? ~lane_write_n_in
                                                         : LANES_NONE);
  wire lanes_seen = !(start_cycle && proc_strobe);
  wire [LANES-1:0] lanes_now = (start_cycle || cont_cycle) && lanes_seen ? lanes_req
                                                                         : LANES_NONE;
  wire write_now = (lanes_now != LANES_NONE);
  wire read_now = (start_cycle || cont_cycle) && !write_now;

  wire [BURST_W-1:0] lo_cur = burst_lo(burst_order_select_in, start_lo_r, cnt_r);
  wire [BURST_W-1:0] lo_step = burst_lo(burst_order_select_in, start_lo_r, cnt_nxt);
  wire [ADDR_W-1:0] acc_addr = start_cycle ? addr_in
                             : {addr_hi_r, step ? lo_step : lo_cur};

  // ----------------------------------------------------------------------
  // Address and burst registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      burst_active_r <= 1'b0;
      addr_hi_r <= ADDR_RST[ADDR_W-1:BURST_W];
      start_lo_r <= CNT_RST;
      cnt_r <= CNT_RST;
    end else if (start_cycle) begin
      burst_active_r <= 1'b1;
      addr_hi_r <= addr_in[ADDR_W-1:BURST_W];
      start_lo_r <= addr_in[BURST_W-1:0];
      cnt_r <= CNT_RST;
    end else if (deselect) begin
      burst_active_r <= 1'b0;
    end else if (step) begin
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Write buffer
  // ----------------------------------------------------------------------
  sbs_wr_entry_t wr_entry;
  sbs_wr_entry_t drain_entry;
  logic [ENTRY_W-1:0] drain_bits;
  logic fifo_in_ready;
  logic drain_valid;
  wire drain_take = drain_valid && running && !read_now;

  assign wr_entry.addr = acc_addr;
  assign wr_entry.lanes = lanes_now;
  assign wr_entry.data = data_in;
  assign drain_entry = sbs_wr_entry_t'(drain_bits);

  sbs_wr_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(WFIFO_DEPTH)
  ) u_wr_fifo (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .in_valid_in(write_now),
    .in_ready_out(fifo_in_ready),
    .in_data_in(wr_entry),
    .out_valid_out(drain_valid),
    .out_ready_in(drain_take),
    .out_data_out(drain_bits)
  );

  // ----------------------------------------------------------------------
  // Array and read pipeline
  // ----------------------------------------------------------------------
  logic [LANES-1:0][LANE_W-1:0] array_mem [WORDS];
  logic [DATA_W-1:0] dout_r;
  logic [DATA_W-1:0] obuf_r;

  always_ff @(posedge core_clk_in) begin
    if (drain_take) begin
      for (int i = 0; i < LANES; i++) begin
        if (drain_entry.lanes[i]) begin
          array_mem[drain_entry.addr][i] <= drain_entry.data[i*LANE_W +: LANE_W];
        end
      end
    end
    if (read_now) begin
      dout_r <= array_mem[acc_addr];
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      obuf_r <= DATA_RST;
    end else if (running) begin
      obuf_r <= dout_r;
    end
  end

  // ----------------------------------------------------------------------
  // Output driver control
  // ----------------------------------------------------------------------
  logic rd_v1_r;
  logic drive_r;
  logic ready_r;
  logic awake_r;

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_v1_r <= 1'b0;
      drive_r <= 1'b0;
      ready_r <= 1'b0;
      awake_r <= 1'b0;
    end else begin
      ready_r <= fifo_in_ready;
      awake_r <= (state_nxt == SBS_RUN);
      if (!running) begin
        drive_r <= 1'b0;
      end else begin
        rd_v1_r <= read_now;
        drive_r <= rd_v1_r && !write_now && !deselect;
      end
    end
  end

  assign data_out = obuf_r;
  assign data_oe_n_out = {LANES{!(drive_r && !output_enable_n_in)}};
  assign write_ready_out = ready_r;
  assign awake_out = awake_r;

endmodule

`default_nettype wire

// File: sbs_burst_sram_chk.sv
/*
  Port checker for the burst memory top, attached by bind.
  Assumes one clock and the active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sbs_burst_sram_chk
  import sbs_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic proc_addr_strobe_n_in,
  input wire logic ctrl_addr_strobe_n_in,
  input wire logic burst_step_n_in,
  input wire logic chip_sel_primary_n_in,
  input wire logic chip_sel_high_in,
  input wire logic chip_sel_secondary_n_in,
  input wire logic [LANES-1:0] lane_write_n_in,
  input wire logic global_write_n_in,
  input wire logic byte_write_enable_n_in,
  input wire logic output_enable_n_in,
  input wire logic sleep_request_in,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic [LANES-1:0] data_oe_n_out,
  input wire logic awake_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  wire logic sel_ok = !chip_sel_primary_n_in && chip_sel_high_in && !chip_sel_secondary_n_in;
  wire logic no_wr = global_write_n_in && (byte_write_enable_n_in || lane_write_n_in == 4'hf);
  wire logic quiet = proc_addr_strobe_n_in && ctrl_addr_strobe_n_in && !output_enable_n_in;
  sequence s_rd_start;
    awake_out && sel_ok && !proc_addr_strobe_n_in && !output_enable_n_in;
  endsequence
  sequence s_rd_next;
    awake_out && quiet && !burst_step_n_in && no_wr;
  endsequence
  a_oe_async: assert property (output_enable_n_in |-> data_oe_n_out == 4'hf)
    else $error("drivers on with output enable off");
  a_rd_enable: assert property (s_rd_start ##1 s_rd_next |=>
    (data_oe_n_out == 4'h0 || !awake_out || output_enable_n_in))
    else $error("read data not driven two cycles after start");
  a_wr_off: assert property (awake_out && proc_addr_strobe_n_in && !no_wr |=>
    data_oe_n_out == 4'hf)
    else $error("drivers on after write sample");
  a_desel_release: assert property (awake_out && !sel_ok && !ctrl_addr_strobe_n_in |=>
    data_oe_n_out == 4'hf)
    else $error("drivers on after deselect");
  a_wait_hold: assert property (awake_out && quiet &&
    burst_step_n_in && no_wr && data_oe_n_out == 4'h0 |=>
    (data_oe_n_out == 4'h0 || !awake_out || output_enable_n_in))
    else $error("wait state dropped read drivers");
  a_sleep_hold: assert property (!awake_out ##1 !awake_out |=> $stable(data_out))
    else $error("output changed while asleep");
  a_sleep_drv: assert property (!awake_out && !$past(awake_out) |-> data_oe_n_out == 4'hf)
    else $error("drivers on while asleep");
  a_wake_gap: assert property ($fell(sleep_request_in) && !awake_out |-> !awake_out [*3])
    else $error("woke too early");
endmodule
bind sbs_burst_sram sbs_burst_sram_chk u_sbs_burst_sram_chk (.core_clk_in, .rstn_in,
  .proc_addr_strobe_n_in, .ctrl_addr_strobe_n_in, .burst_step_n_in, .chip_sel_primary_n_in,
  .chip_sel_high_in, .chip_sel_secondary_n_in, .lane_write_n_in, .global_write_n_in,
  .byte_write_enable_n_in, .output_enable_n_in, .sleep_request_in, .data_out,
  .data_oe_n_out, .awake_out);
`default_nettype wire

// File: sbs_burst_sram_tb.sv
/*
  Self-checking bench for the burst memory port with its far-side bus model.
  Assumes the checker is bound to the top from its own file.
*/
`timescale 1ns/1ps
`default_nettype none
module sbs_burst_sram_tb;
  import sbs_pkg::*;
  localparam logic [ADDR_W-1:0] BASE = 15'h1a4c;
  logic clk = 1'b0, rst_n = 1'b0, p_n = 1'b1, c_n = 1'b1, adv_n = 1'b1, gw_n = 1'b1;
  logic cs1_n = 1'b0, cs_hi = 1'b1, cs2_n = 1'b0, bw_n = 1'b1, oe_n = 1'b1;
  logic sleep = 1'b0, burst_order_select = 1'b0, hdrv = 1'b0, wr_rdy, awake;
  logic [3:0] we_n = 4'hf;
  logic [3:0] doe_n;
  logic [ADDR_W-1:0] addr = BASE;
  logic [DATA_W-1:0] hdata = 32'h0, bus, dout;
  logic [DATA_W-1:0] mem [4];
  int error_cnt = 0, total_checks = 0;
  initial forever #12.5 clk = ~clk;
  sbs_burst_sram u_sbs_burst_sram (.core_clk_in(clk), .rstn_in(rst_n), .addr_in(addr),
    .proc_addr_strobe_n_in(p_n), .ctrl_addr_strobe_n_in(c_n), .burst_step_n_in(adv_n),
    .chip_sel_primary_n_in(cs1_n), .chip_sel_high_in(cs_hi), .chip_sel_secondary_n_in(cs2_n),
    .lane_write_n_in(we_n), .global_write_n_in(gw_n), .byte_write_enable_n_in(bw_n),
    .output_enable_n_in(oe_n), .sleep_request_in(sleep), .burst_order_select_in(burst_order_select),
    .data_in(bus), .data_out(dout), .data_oe_n_out(doe_n), .write_ready_out(wr_rdy),
    .awake_out(awake));
  sbs_bus_host u_sbs_bus_host (.core_clk_in(clk), .host_drive_in(hdrv), .host_data_in(hdata),
    .dev_data_in(dout), .dev_oe_n_in(doe_n), .bus_out(bus));
  task automatic chk_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_ctl(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected control at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input logic [3:0] ctl, input logic [3:0] w, input logic [1:0] lo,
      input logic [DATA_W-1:0] d);
    {p_n, c_n, adv_n, gw_n} = ctl;
    we_n = w;
    addr = BASE | {13'h0, lo};
    hdata = d;
    @(negedge clk);
  endtask
  task automatic desel;
    cs_hi = 1'b0;
    tick(4'hb, 4'hf, 2'h0, 32'h0);
    cs_hi = 1'b1;
    repeat (8) tick(4'hf, 4'hf, 2'h0, 32'h0);
  endtask
  task automatic wr(input logic g, input logic [3:0] w, input int n, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] v;
    oe_n = 1'b1;
    hdrv = 1'b1;
    bw_n = 1'b0;
    burst_order_select = 1'b0;
    for (int k = 0; k < n; k++) begin
      v = d + DATA_W'(k);
      tick({1'b1, k != 0, 1'b0, g}, w, 2'h0, v);
      chk_ctl(doe_n, 4'hf);
      for (int j = 0; j < LANES; j++) begin
        if (!g || !w[j]) mem[k][j*LANE_W +: LANE_W] = v[j*LANE_W +: LANE_W];
      end
    end
    hdrv = 1'b0;
    bw_n = 1'b1;
    desel();
  endtask
  task automatic rd(input logic order, input logic [1:0] s, input logic hold);
    logic [1:0] i;
    burst_order_select = order;
    oe_n = 1'b0;
    bw_n = 1'b0;
    tick(4'h2, 4'h0, s, 32'h0);
    bw_n = 1'b1;
    chk_ctl(doe_n, 4'hf);
    for (int k = 0; k < 4 + int'(hold); k++) begin
      tick((hold && k == 1) ? 4'hf : 4'hd, 4'hf, s, 32'h0);
      i = 2'(k) - {1'b0, hold && k >= 2};
      i = order ? (s ^ i) : (s + i);
      chk_data(dout, mem[i]);
      chk_ctl(doe_n, 4'h0);
      if (k == 0) begin
        oe_n = 1'b1;
        #1 chk_ctl(doe_n, 4'hf);
        oe_n = 1'b0;
      end
    end
    oe_n = 1'b1;
    desel();
  endtask
  task automatic sel_block;
    oe_n = 1'b0;
    for (int m = 0; m < 2; m++) begin
      {cs1_n, cs2_n} = m ? 2'b01 : 2'b10;
      tick(4'h7, 4'hf, 2'h0, 32'h0);
      tick(4'hd, 4'hf, 2'h0, 32'h0);
      tick(4'hd, 4'hf, 2'h0, 32'h0);
      chk_ctl(doe_n, 4'hf);
    end
    {cs1_n, cs2_n} = 2'b00;
    oe_n = 1'b1;
  endtask
  task automatic sleep_test;
    int n;
    sleep = 1'b1;
    repeat (6) @(negedge clk);
    chk_ctl({3'h0, awake}, 4'h0);
    sleep = 1'b0;
    n = 0;
    while (awake !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    chk_ctl({3'h0, awake}, 4'h1);
    chk_ctl({3'h0, n > WAKE_CYCLES}, 4'h1);
    rd(1'b0, 2'h0, 1'b0);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk_ctl({2'h0, awake, wr_rdy}, 4'h3);
    chk_ctl(doe_n, 4'hf);
    wr(1'b0, 4'hf, 4, 32'ha5a50000);
    rd(1'b0, 2'h2, 1'b0);
    rd(1'b1, 2'h1, 1'b1);
    wr(1'b1, 4'ha, 1, 32'h11223344);
    rd(1'b0, 2'h0, 1'b0);
    sel_block();
    sleep_test();
    final_report();
  end
  initial begin
    #50000;
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire

// File: sbs_bus_host.sv
/*
  Far-side bus model: resolves the shared data bus between host and device.
  Assumes the host raises its drive only while the device lanes are off.
*/
`timescale 1ns/1ps
`default_nettype none
module sbs_bus_host
  import sbs_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic host_drive_in,
  input wire logic [DATA_W-1:0] host_data_in,
  input wire logic [DATA_W-1:0] dev_data_in,
  input wire logic [LANES-1:0] dev_oe_n_in,
  output logic [DATA_W-1:0] bus_out
);
  logic [DATA_W-1:0] last_r;
  always_ff @(posedge core_clk_in) begin
    last_r <= bus_out;
  end
  always_comb begin
    for (int j = 0; j < LANES; j++) begin
      if (host_drive_in && !dev_oe_n_in[j]) begin
        bus_out[j*LANE_W +: LANE_W] = {LANE_W{1'bx}};
      end else if (host_drive_in) begin
        bus_out[j*LANE_W +: LANE_W] = host_data_in[j*LANE_W +: LANE_W];
      end else if (!dev_oe_n_in[j]) begin
        bus_out[j*LANE_W +: LANE_W] = dev_data_in[j*LANE_W +: LANE_W];
      end else begin
        bus_out[j*LANE_W +: LANE_W] = ~last_r[j*LANE_W +: LANE_W];
      end
    end
  end
endmodule
`default_nettype wire

// File: sbs_pkg.sv
/*
  Shared constants and types for the synchronous pipelined burst memory port.
  Assumes a single system clock; every user of the package imports it whole.
*/
`default_nettype none

package sbs_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int BURST_W = 2;
  localparam int WORDS = 32768;

  // ----------------------------------------------------------------------
  // Timing and buffering
  // ----------------------------------------------------------------------
  localparam int WAKE_CYCLES = 2;
  localparam int WAKE_W = 2;
  localparam int WFIFO_DEPTH = 32;
  localparam int SYNC_STAGES = 3;

  // ----------------------------------------------------------------------
  // Reset values and lane masks
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  localparam logic [BURST_W-1:0] CNT_RST = 2'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
  localparam logic [LANES-1:0] LANES_ALL = 4'hf;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [WAKE_W-1:0] WAKE_RST = 2'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SBS_RUN = 2'b00,
    SBS_SLEEP = 2'b01,
    SBS_WAKE = 2'b10
  } sbs_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lanes;
    logic [DATA_W-1:0] data;
  } sbs_wr_entry_t;

  localparam int ENTRY_W = ADDR_W + LANES + DATA_W;

endpackage

`default_nettype wire
